// ---- srg_defines.svh ----
// Register map, reset values, limits and timing figures of the speed ramp generator
`ifndef SRG_DEFINES_SVH
`define SRG_DEFINES_SVH

// Register indices; byte address is four times the index
`define SRG_IDX_ACCEL      10'h144
`define SRG_IDX_DECEL      10'h146
`define SRG_IDX_SCURVE     10'h148
`define SRG_IDX_CTRL       10'h14A
`define SRG_IDX_SPEED      10'h14C
`define SRG_IDX_STATUS     10'h14E

// Reset values
`define SRG_ACCEL_RST      16'h00C8
`define SRG_DECEL_RST      16'h00C8
`define SRG_SCURVE_RST     16'h0000

// Legal setting ranges
`define SRG_RAMP_MIN       16'h0001
`define SRG_SCURVE_MIN     16'h0000
`define SRG_TIME_MAX       16'hFFDC
`define SRG_ANA_RAMP_MAX   16'h4E20
`define SRG_ANA_SCURVE_MAX 16'h2710

// Control and status bit positions
`define SRG_CTRL_ANALOG    0
`define SRG_CTRL_POSMODE   1
`define SRG_STAT_BUSY      0
`define SRG_STAT_BYPASS    1

// Full acceleration level, unity in Q16
`define SRG_ACCEL_FULL     17'h10000
`define SRG_DIV_BITS       6'h20

// Time base
`define SRG_CLK_HZ         50000000
`define SRG_TICK_MS        1
`define SRG_TICK_CYCLES    (`SRG_CLK_HZ / 1000 * `SRG_TICK_MS)

// AXI responses
`define SRG_RESP_OKAY      2'b00
`define SRG_RESP_SLVERR    2'b10
`define SRG_RESP_DECERR    2'b11

`endif

// ---- srg_pkg.sv ----
// Types of the speed ramp generator
package srg_pkg;

  typedef enum logic [1:0] {
    SRG_IDLE     = 2'b00,
    SRG_DIV_INC  = 2'b01,
    SRG_DIV_JERK = 2'b10,
    SRG_STEP     = 2'b11
  } srg_phase_t;

  typedef struct packed {
    logic        aw_got;
    logic [9:0]  aw_idx;
    logic        w_got;
    logic [15:0] w_data;
    logic [1:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [15:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] accel_ramp_time;
    logic [15:0] decel_ramp_time;
    logic [15:0] scurve_round_time;
    logic        analog_src;
    logic        internal_position_mode;
    srg_phase_t  phase;
    logic [15:0] tick;
    logic [31:0] dvd;
    logic [16:0] div;
    logic [17:0] rem;
    logic [31:0] quo;
    logic [5:0]  bits;
    logic [31:0] inc;
    logic [31:0] jerk;
    logic [15:0] seg;
    logic [16:0] alev;
    logic [15:0] nup;
    logic [39:0] spd;
    logic        busy;
    logic        bypass;
  } srg_state_t;

endpackage

// ---- srg_ramp.sv ----
// Speed command ramp generator with S-curve rounding and AXI4-Lite registers
//
// Overview of operation
// - Acceleration time sets ms from zero to rated speed; range 1..65500, default 200.
// - Deceleration time sets ms from rated speed to zero; range 1..65500, default 200.
// - S-curve time accepts 0..65500 ms, default 0; zero disables rounding.
// - S-curve rounds ramp start and end, each rounded segment half the S-curve time.
// - Whole acceleration lasts acceleration time plus S-curve time.
// - Whole deceleration lasts deceleration time plus S-curve time.
// - The three times act independently; zero S-curve keeps linear ramps working.
// - With analog speed source, acceleration time is limited to 20000.
// - With analog speed source, deceleration time is limited to 20000.
// - With analog speed source, S-curve time is limited to 10000.
// - Analog source with zero S-curve time bypasses the ramp entirely.
// - Ramp times act in speed mode; S-curve also in internal position mode.
`timescale 1ns/1ps
`include "srg_defines.svh"
`default_nettype none

module srg_ramp #(
  parameter int TICK_CYCLES = `SRG_TICK_CYCLES,
  parameter int RATED_SPEED = 3000
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // AXI4-Lite write address and data
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Speed command in, ramped speed out
  input  wire logic [15:0] SPEED_CMD,
  output logic [15:0]      SPEED_OUT,
  output logic             RAMP_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: two 32-step divisions must fit in one tick

  if (TICK_CYCLES < 80 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end
  if (RATED_SPEED < 1 || RATED_SPEED > 32767) begin : g_bad_rated
    $error("RATED_SPEED out of range");
  end

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  // Rated speed sits in the upper half of the Q16 dividend
  localparam logic [31:0] RATED_Q16 = {16'(RATED_SPEED), 16'h0000};

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Byte lanes follow the write strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // Magnitude of a signed Q16 speed difference
  function automatic logic [39:0] abs40(input logic [39:0] v);
    abs40 = v[39] ? 40'(-$signed(v)) : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  srg_pkg::srg_state_t s;
  srg_pkg::srg_state_t next_s;

  // Ready drops while a response waits, so one write at most is in flight
  assign S_AXI_AWREADY = !s.aw_got && !s.bvalid;
  assign S_AXI_WREADY  = !s.w_got && !s.bvalid;
  assign S_AXI_BVALID  = s.bvalid;
  assign S_AXI_BRESP   = s.bresp;
  assign S_AXI_ARREADY = !s.rvalid;
  assign S_AXI_RVALID  = s.rvalid;
  assign S_AXI_RRESP   = s.rresp;
  assign S_AXI_RDATA   = {16'h0000, s.rdata};
  // Integer part of the Q16 speed; the fraction keeps slow ramps exact
  assign SPEED_OUT     = s.spd[31:16];
  assign RAMP_ACTIVE   = s.busy;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [15:0] acc_e;
    logic [15:0] dec_e;
    logic [15:0] tsl_e;
    logic [39:0] target;
    logic [39:0] diff;
    logic [39:0] mag;
    logic        away;
    logic [15:0] ramp_t;
    logic [15:0] seg;
    logic [17:0] r;
    logic        qbit;
    logic [31:0] q;
    logic [48:0] prod;
    logic [31:0] step;
    logic [47:0] brake;
    logic [16:0] a;
    acc_e  = s.accel_ramp_time;
    dec_e  = s.decel_ramp_time;
    tsl_e  = s.scurve_round_time;
    target = {{8{SPEED_CMD[15]}}, SPEED_CMD, 16'h0000};
    diff   = 40'($signed(target) - $signed(s.spd));
    mag    = abs40(diff);
    away   = (!s.spd[39] && !diff[39]) || (s.spd[39] && diff[39]);
    ramp_t = 16'h0000;
    seg    = 16'h0000;
    r      = {s.rem[16:0], s.dvd[31]};
    qbit   = (r >= {1'b0, s.div});
    q      = {s.quo[30:0], qbit};
    prod   = 49'(s.inc * s.alev);
    step   = prod[47:16];
    brake  = 48'h0;
    a      = s.alev;
    next_s = s;

    // Analog limits act on the value used; the stored setting stays as written
    if (s.analog_src) begin
      acc_e = clamp16(s.accel_ramp_time, `SRG_RAMP_MIN, `SRG_ANA_RAMP_MAX);
      dec_e = clamp16(s.decel_ramp_time, `SRG_RAMP_MIN, `SRG_ANA_RAMP_MAX);
      tsl_e = clamp16(s.scurve_round_time, `SRG_SCURVE_MIN, `SRG_ANA_SCURVE_MAX);
    end

    // AXI write: address and data taken independently, answered together
    if (S_AXI_AWVALID && !s.aw_got && !s.bvalid) begin
      next_s.aw_got = 1'b1;
      next_s.aw_idx = S_AXI_AWADDR[11:2];
    end
    if (S_AXI_WVALID && !s.w_got && !s.bvalid) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = S_AXI_WDATA[15:0];
      next_s.w_strb = S_AXI_WSTRB[1:0];
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `SRG_RESP_OKAY;
      // Out-of-range settings are clamped on write rather than refused
      case (s.aw_idx)
        `SRG_IDX_ACCEL: begin
          next_s.accel_ramp_time = clamp16(merge16(s.accel_ramp_time, s.w_data, s.w_strb),
                                           `SRG_RAMP_MIN, `SRG_TIME_MAX);
        end
        `SRG_IDX_DECEL: begin
          next_s.decel_ramp_time = clamp16(merge16(s.decel_ramp_time, s.w_data, s.w_strb),
                                           `SRG_RAMP_MIN, `SRG_TIME_MAX);
        end
        `SRG_IDX_SCURVE: begin
          next_s.scurve_round_time = clamp16(merge16(s.scurve_round_time, s.w_data, s.w_strb),
                                             `SRG_SCURVE_MIN, `SRG_TIME_MAX);
        end
        `SRG_IDX_CTRL: begin
          if (s.w_strb[0]) begin
            next_s.analog_src             = s.w_data[`SRG_CTRL_ANALOG];
            next_s.internal_position_mode = s.w_data[`SRG_CTRL_POSMODE];
          end
        end
        `SRG_IDX_SPEED, `SRG_IDX_STATUS: begin
          next_s.bresp = `SRG_RESP_SLVERR;
        end
        default: begin
          next_s.bresp = `SRG_RESP_DECERR;
        end
      endcase
    end
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end

    // AXI read: one outstanding, data registered
    if (S_AXI_ARVALID && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `SRG_RESP_OKAY;
      case (S_AXI_ARADDR[11:2])
        `SRG_IDX_ACCEL:  next_s.rdata = s.accel_ramp_time;
        `SRG_IDX_DECEL:  next_s.rdata = s.decel_ramp_time;
        `SRG_IDX_SCURVE: next_s.rdata = s.scurve_round_time;
        `SRG_IDX_CTRL: begin
          next_s.rdata = 16'h0000;
          next_s.rdata[`SRG_CTRL_ANALOG]  = s.analog_src;
          next_s.rdata[`SRG_CTRL_POSMODE] = s.internal_position_mode;
        end
        `SRG_IDX_SPEED: next_s.rdata = s.spd[31:16];
        `SRG_IDX_STATUS: begin
          next_s.rdata = 16'h0000;
          next_s.rdata[`SRG_STAT_BUSY]   = s.busy;
          next_s.rdata[`SRG_STAT_BYPASS] = s.bypass;
        end
        default: begin
          next_s.rdata = 16'h0000;
          next_s.rresp = `SRG_RESP_DECERR;
        end
      endcase
    end else if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end

    // Millisecond time base
    // Free-running from reset; the first update comes one tick after release
    next_s.tick = (s.tick == TICK_LAST) ? 16'h0000 : 16'(s.tick + 16'h0001);

    case (s.phase)
      srg_pkg::SRG_IDLE: begin
        if (s.tick == TICK_LAST) begin
          next_s.bypass = s.analog_src && (tsl_e == 16'h0000);
          if (s.analog_src && tsl_e == 16'h0000) begin
            // Analog source with no rounding follows the command directly
            next_s.spd  = target;
            next_s.busy = 1'b0;
            next_s.alev = 17'h0;
            next_s.nup  = 16'h0;
          end else begin
            // Ramp time is chosen here by direction; the step takes its direction again from the current command
            // Position mode ignores the ramp times and uses the 1 ms minimum ramp time plus the rounding
            ramp_t = s.internal_position_mode ? `SRG_RAMP_MIN : (away ? acc_e : dec_e);
            seg    = {1'b0, tsl_e[15:1]};
            if (tsl_e != 16'h0000 && seg == 16'h0000) begin
              seg = 16'h0001;
            end
            // Peak slope over ramp + seg so total time is ramp + S-curve
            next_s.seg   = seg;
            next_s.div   = 17'(ramp_t + seg);
            next_s.dvd   = RATED_Q16;
            next_s.rem   = 18'h0;
            next_s.quo   = 32'h0;
            next_s.bits  = `SRG_DIV_BITS;
            next_s.phase = srg_pkg::SRG_DIV_INC;
          end
        end
      end
      srg_pkg::SRG_DIV_INC, srg_pkg::SRG_DIV_JERK: begin
        // Serial divider trades latency inside the tick for a small area
        // Restoring division, one quotient bit per clock
        next_s.rem  = qbit ? 18'(r - {1'b0, s.div}) : r;
        next_s.dvd  = {s.dvd[30:0], 1'b0};
        next_s.quo  = q;
        next_s.bits = 6'(s.bits - 6'h01);
        if (s.bits == 6'h01) begin
          if (s.phase == srg_pkg::SRG_DIV_INC) begin
            next_s.inc = q;
            if (s.seg == 16'h0000) begin
              next_s.phase = srg_pkg::SRG_STEP;
            end else begin
              next_s.dvd   = {15'h0, `SRG_ACCEL_FULL};
              next_s.div   = {1'b0, s.seg};
              next_s.rem   = 18'h0;
              next_s.quo   = 32'h0;
              next_s.bits  = `SRG_DIV_BITS;
              next_s.phase = srg_pkg::SRG_DIV_JERK;
            end
          end else begin
            next_s.jerk  = q;
            next_s.phase = srg_pkg::SRG_STEP;
          end
        end
      end
      srg_pkg::SRG_STEP: begin
        next_s.phase = srg_pkg::SRG_IDLE;
        if (s.seg == 16'h0000) begin
          a = `SRG_ACCEL_FULL;
        end
        // One LSB minimum keeps a zero-acceleration tick from stalling the ramp
        prod  = 49'(s.inc * a);
        step  = (prod[47:16] == 32'h0) ? 32'h1 : prod[47:16];
        brake = 48'(step * s.nup) >> 1;
        if (mag == 40'h0) begin
          next_s.busy = 1'b0;
          next_s.alev = 17'h0;
          next_s.nup  = 16'h0;
        end else if (mag <= {8'h00, step}) begin
          next_s.spd  = target;
          next_s.busy = 1'b0;
          next_s.alev = 17'h0;
          next_s.nup  = 16'h0;
        end else begin
          next_s.busy = 1'b1;
          next_s.spd  = diff[39] ? 40'(s.spd - {8'h00, step}) : 40'(s.spd + {8'h00, step});
          if (s.seg != 16'h0000) begin
            // Rounded end: ease acceleration off once the stopping gain covers the rest
            if ({8'h00, mag} <= brake && s.nup != 16'h0000) begin
              // Compared one bit wider so a one-tick segment cannot wrap to zero
              next_s.alev = ({1'b0, s.alev} > {s.jerk[16:0], 1'b0}) ?
                            17'(s.alev - s.jerk[16:0]) : s.jerk[16:0];
              next_s.nup  = 16'(s.nup - 16'h0001);
            end else if (s.alev < `SRG_ACCEL_FULL) begin
              next_s.alev = ({15'h0, s.alev} + s.jerk >= {15'h0, `SRG_ACCEL_FULL}) ?
                            `SRG_ACCEL_FULL : 17'(s.alev + s.jerk[16:0]);
              next_s.nup  = 16'(s.nup + 16'h0001);
            end
          end
        end
      end
      default: begin
        next_s.phase = srg_pkg::SRG_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  // Ramp settings leave reset at their default times
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s                        <= '0;
      s.accel_ramp_time        <= `SRG_ACCEL_RST;
      s.decel_ramp_time        <= `SRG_DECEL_RST;
      s.scurve_round_time      <= `SRG_SCURVE_RST;
      s.phase                  <= srg_pkg::SRG_IDLE;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// ---- srg_ramp_sva.sv ----
// Assertion checker for the speed ramp generator ports
`timescale 1ns/1ps
`default_nettype none
module srg_ramp_sva (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  // Register bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // Speed link
  input wire logic [15:0] SPEED_CMD,
  input wire logic [15:0] SPEED_OUT,
  input wire logic        RAMP_ACTIVE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////////
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  a_b_blocks: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken during response");
  a_r_blocks: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken during response");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID && S_AXI_RDATA[31:16] == 16'h0000) else $error("read answer late");
  a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID) else $error("write answer late");
  // Tick is far longer than eight cycles, so two updates this close are a fault
  a_tick_rate: assert property ($changed(SPEED_OUT) |=> $stable(SPEED_OUT)[*8])
    else $error("output stepped twice in one tick");
  a_settled: assert property ($changed(SPEED_OUT) && !RAMP_ACTIVE |->
    SPEED_OUT == SPEED_CMD) else $error("ramp ended off command");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_ramp_end: cover property ($fell(RAMP_ACTIVE));
endmodule
bind srg_ramp srg_ramp_sva u_sva (.REF_CLK, .RST_B, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY,
  .SPEED_CMD, .SPEED_OUT, .RAMP_ACTIVE);
`default_nettype wire

// ---- srg_loop_model.sv ----
// Command source and speed loop model, counts output updates per ramp
`timescale 1ns/1ps
`default_nettype none
module srg_loop_model #(
  parameter int TICK_CYCLES = 100
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Bench request and block output
  input wire logic [15:0] cmd_req,
  input wire logic [15:0] speed_out,
  // Command to block, update count
  output logic [15:0]     speed_cmd,
  output logic [15:0]     steps
);
  logic [15:0] prev;
  logic [15:0] tick;
  // Command moves late in a tick, after the step and before the next sample
  // Count restarts on a new command so each ramp is measured alone
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_cmd <= 16'h0000;
      steps <= 16'h0000;
      prev <= 16'h0000;
      tick <= 16'h0000;
    end else begin
      prev <= speed_out;
      tick <= (tick == 16'(TICK_CYCLES - 1)) ? 16'h0000 : 16'(tick + 16'h0001);
      if (cmd_req != speed_cmd && tick == 16'(TICK_CYCLES - 10)) begin
        speed_cmd <= cmd_req;
        steps <= 16'h0000;
      end else if (speed_out != prev) begin
        steps <= steps + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test_srg_ramp.sv ----
// Self-checking testbench of the speed ramp generator
`timescale 1ns/1ps
`include "srg_defines.svh"
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_srg_ramp;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, act;
  logic [1:0] bresp, rresp;
  logic [15:0] cmd_req = 16'h0000, cmd, sout, steps;
  int error_cnt = 0;
  int comparisons = 0;
  localparam int TICK = 100;
  srg_ramp #(.TICK_CYCLES(TICK), .RATED_SPEED(3000)) u_dut (.REF_CLK(clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .SPEED_CMD(cmd), .SPEED_OUT(sout), .RAMP_ACTIVE(act));
  srg_loop_model #(.TICK_CYCLES(TICK)) u_loop (.clk(clk), .rst_b(rst_b), .cmd_req(cmd_req),
    .speed_out(sout),
    .speed_cmd(cmd), .steps(steps));
  initial begin
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Ready is sampled at the falling edge, where it is settled before the handshake edge
  task automatic wr(input logic [9:0] i, input logic [15:0] d, input logic [1:0] r);
    logic ga, gw, a, w, v;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ga && gw)) begin
      @(negedge clk);
      a = awv && awr;
      w = wv && wr_rdy;
      @(posedge clk);
      if (a) awv <= 1'b0;
      if (w) wv <= 1'b0;
      ga = ga | a;
      gw = gw | w;
    end
    bready <= 1'b1;
    do begin
      @(negedge clk);
      v = bv;
      if (v) `CHK("bresp", r, bresp)
      @(posedge clk);
    end while (!v);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i, input logic [15:0] d, input logic [1:0] r);
    logic a, v;
    logic [31:0] dat;
    logic [1:0] rsp;
    @(posedge clk);
    araddr <= {i, 2'b00};
    arv <= 1'b1;
    do begin
      @(negedge clk);
      a = arr;
      @(posedge clk);
    end while (!a);
    arv <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      v = rv;
      dat = rdata;
      rsp = rresp;
      @(posedge clk);
    end while (!v);
    rready <= 1'b0;
    `CHK("rdata", {16'h0000, d}, dat)
    `CHK("rresp", r, rsp)
  endtask
  // Ramp to a command and judge the number of ticks that moved the output
  task automatic go(input logic [15:0] c, input logic [15:0] lo, input logic [15:0] hi);
    @(posedge clk);
    cmd_req <= c;
    repeat (3) @(posedge clk);
    while (sout !== c || act !== 1'b0) @(negedge clk);
    repeat (3) @(posedge clk);
    `CHK("steps", 1'b1, steps >= lo && steps <= hi)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(`SRG_IDX_ACCEL, 16'h00C8, 2'b00);
    rd(`SRG_IDX_DECEL, 16'h00C8, 2'b00);
    rd(`SRG_IDX_SCURVE, 16'h0000, 2'b00);
    rd(10'h100, 16'h0000, `SRG_RESP_DECERR);
    wr(`SRG_IDX_ACCEL, 16'h0000, 2'b00);
    rd(`SRG_IDX_ACCEL, 16'h0001, 2'b00);
    wr(`SRG_IDX_DECEL, 16'hFFFF, 2'b00);
    rd(`SRG_IDX_DECEL, 16'hFFDC, 2'b00);
    wr(`SRG_IDX_SCURVE, 16'hFFFF, 2'b00);
    rd(`SRG_IDX_SCURVE, 16'hFFDC, 2'b00);
    wr(`SRG_IDX_SPEED, 16'h1234, `SRG_RESP_SLVERR);
  endtask
  task automatic t_ramps;
    wr(`SRG_IDX_ACCEL, 16'd10, 2'b00);
    wr(`SRG_IDX_DECEL, 16'd5, 2'b00);
    wr(`SRG_IDX_SCURVE, 16'd0, 2'b00);
    go(16'd3000, 16'd10, 16'd10);
    rd(`SRG_IDX_SPEED, 16'd3000, 2'b00);
    go(16'd0, 16'd5, 16'd5);
    // End rounding is approximate, so allow a few ticks either way
    wr(`SRG_IDX_SCURVE, 16'd4, 2'b00);
    go(16'd3000, 16'd12, 16'd16);
    go(16'd0, 16'd7, 16'd11);
  endtask
  task automatic t_modes;
    wr(`SRG_IDX_SCURVE, 16'd0, 2'b00);
    wr(`SRG_IDX_CTRL, 16'h0001, 2'b00);
    // Bypass flag is only taken up at the next tick
    repeat (2 * TICK) @(posedge clk);
    rd(`SRG_IDX_STATUS, 16'h0002, 2'b00);
    go(16'd3000, 16'd1, 16'd1);
    wr(`SRG_IDX_CTRL, 16'h0002, 2'b00);
    go(16'd0, 16'd1, 16'd1);
  endtask
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_ramps;
    t_modes;
    end_sim;
  end
  // Whole run is a few thousand cycles; this span leaves a wide margin
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
